//--- shared/uei_pkg.sv
// Shared constants, register map and CRC helpers for the USB error interrupt block
package uei_pkg;

  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned IDLE_TIME_US = 3000;
  localparam int unsigned IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
  localparam int unsigned BIT_CYCLES = 4;
  localparam logic [1:0] BIT_DIV_LAST = 2'(BIT_CYCLES - 1);
  localparam logic [4:0] TURNAROUND_BITS = 5'h10;

  localparam logic [7:0] ERR_FLAG_OFS = 8'h00;
  localparam logic [7:0] ERR_EN_OFS = 8'h04;
  localparam logic [7:0] STAT_FLAG_OFS = 8'h08;
  localparam logic [7:0] STAT_EN_OFS = 8'h0C;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] TX_OFS = 8'h14;

  localparam int unsigned ERR_STUFF_BIT = 7;
  localparam int unsigned ERR_TURN_BIT = 4;
  localparam int unsigned ERR_BYTES_BIT = 3;
  localparam int unsigned ERR_CRC16_BIT = 2;
  localparam int unsigned ERR_CRC5_BIT = 1;
  localparam int unsigned ERR_PID_BIT = 0;
  localparam logic [7:0] ERR_IMPL_MASK = 8'h9F;
  localparam logic [7:0] ERR_FLAG_RESET = 8'h00;
  localparam logic [7:0] ERR_EN_RESET = 8'h00;

  localparam int unsigned STAT_ERR_BIT = 1;
  localparam int unsigned STAT_TXDONE_BIT = 3;
  localparam int unsigned STAT_IDLE_BIT = 4;
  localparam logic [7:0] STAT_STICKY_MASK = 8'h18;
  localparam logic [7:0] STAT_IMPL_MASK = 8'h1A;
  localparam logic [7:0] STAT_RESET = 8'h00;

  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_PULLUP_BIT = 1;
  localparam int unsigned CTRL_ATTACH_BIT = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  localparam int unsigned TX_LAST_BIT = 8;
  localparam int unsigned TX_BUSY_BIT = 9;

  localparam logic [2:0] STUFF_RUN = 3'h6;
  localparam logic [1:0] PID_TOKEN = 2'h1;
  localparam logic [1:0] PID_DATA = 2'h3;
  localparam logic [4:0] CRC5_INIT = 5'h1F;
  localparam logic [4:0] CRC5_POLY = 5'h05;
  localparam logic [4:0] CRC5_RESIDUE = 5'h0C;
  localparam logic [15:0] CRC16_INIT = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY = 16'h8005;
  localparam logic [15:0] CRC16_RESIDUE = 16'h800D;

  typedef enum logic [1:0] {
    UEI_TX_IDLE = 2'b00,
    UEI_TX_DATA = 2'b01,
    UEI_TX_HOLD = 2'b10,
    UEI_TX_EOP = 2'b11
  } uei_tx_state_t;

  function automatic logic [4:0] uei_crc5_step(input logic [4:0] crc, input logic d);
    uei_crc5_step = {crc[3:0], 1'b0} ^ ((d ^ crc[4]) ? CRC5_POLY : 5'h00);
  endfunction

  function automatic logic [15:0] uei_crc16_step(input logic [15:0] crc, input logic d);
    uei_crc16_step = {crc[14:0], 1'b0} ^ ((d ^ crc[15]) ? CRC16_POLY : 16'h0000);
  endfunction

endpackage

//--- logic/uei_rx_check.sv
// Receive path: NRZI decode, unstuffing, PID and CRC checks, error pulses
`timescale 1ns/1ns
module uei_rx_check (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_en,
  input wire logic enable,
  input wire logic rx_line,
  input wire logic rx_se0,
  output logic [7:0] err_evt,
  output logic pkt_start,
  output logic pkt_end
);

  typedef struct packed {
    logic in_pkt;
    logic drain;
    logic prev_line;
    logic [2:0] ones;
    logic [10:0] nbits;
    logic [7:0] shreg;
    logic [1:0] pid_type;
    logic [4:0] crc5;
    logic [15:0] crc16;
    logic [7:0] err_evt;
    logic pkt_start;
    logic pkt_end;
  } uei_rx_t;

  uei_rx_t r;
  uei_rx_t next_r;

  always_comb begin
    logic d;
    logic [7:0] byte_now;
    d = 1'b0;
    byte_now = 8'h00;
    next_r = r;
    next_r.err_evt = 8'h00;
    next_r.pkt_start = 1'b0;
    next_r.pkt_end = 1'b0;
    if (!enable) begin
      next_r.in_pkt = 1'b0;
      next_r.drain = 1'b0;
      next_r.prev_line = 1'b1;
    end else if (bit_en) begin
      if (r.drain) begin
        if (rx_se0) begin
          next_r.drain = 1'b0;
          next_r.prev_line = 1'b1;
          next_r.pkt_end = 1'b1;
        end
      end else if (!r.in_pkt) begin
        // First K after idle J is the opening sync bit
        if (!rx_se0 && !rx_line) begin
          next_r.in_pkt = 1'b1;
          next_r.prev_line = 1'b0;
          next_r.ones = 3'h0;
          next_r.nbits = 11'h001;
          next_r.crc5 = uei_pkg::CRC5_INIT;
          next_r.crc16 = uei_pkg::CRC16_INIT;
          next_r.pkt_start = 1'b1;
        end
      end else if (rx_se0) begin
        next_r.in_pkt = 1'b0;
        next_r.prev_line = 1'b1;
        next_r.pkt_end = 1'b1;
        if (r.nbits[2:0] != 3'h0) begin
          next_r.err_evt[uei_pkg::ERR_BYTES_BIT] = 1'b1; // RQ3
        end
        if (r.nbits > 11'h010) begin
          if (r.pid_type == uei_pkg::PID_TOKEN && r.crc5 != uei_pkg::CRC5_RESIDUE) begin
            next_r.err_evt[uei_pkg::ERR_CRC5_BIT] = 1'b1; // RQ5
          end
          if (r.pid_type == uei_pkg::PID_DATA && r.crc16 != uei_pkg::CRC16_RESIDUE) begin
            next_r.err_evt[uei_pkg::ERR_CRC16_BIT] = 1'b1; // RQ4
          end
        end
      end else begin
        d = (rx_line == r.prev_line); // RQ14
        next_r.prev_line = rx_line;
        if (r.ones == uei_pkg::STUFF_RUN) begin
          next_r.ones = 3'h0;
          if (d) begin
            // Seventh one: packet is lost, wait out its end
            next_r.err_evt[uei_pkg::ERR_STUFF_BIT] = 1'b1; // RQ1
            next_r.in_pkt = 1'b0;
            next_r.drain = 1'b1;
          end
        end else begin
          next_r.ones = d ? r.ones + 3'h1 : 3'h0;
          byte_now = {d, r.shreg[7:1]};
          next_r.shreg = byte_now;
          next_r.nbits = r.nbits + 11'h001;
          if (r.nbits == 11'h00F) begin
            next_r.pid_type = byte_now[1:0];
            if (byte_now[3:0] != ~byte_now[7:4]) begin
              next_r.err_evt[uei_pkg::ERR_PID_BIT] = 1'b1; // RQ6
            end
          end
          if (r.nbits >= 11'h010) begin
            next_r.crc5 = uei_pkg::uei_crc5_step(r.crc5, d); // RQ14
            next_r.crc16 = uei_pkg::uei_crc16_step(r.crc16, d);
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{in_pkt: 1'b0, drain: 1'b0, prev_line: 1'b1, ones: 3'h0, nbits: 11'h000,
             shreg: 8'h00, pid_type: 2'h0, crc5: 5'h1F, crc16: 16'hFFFF,
             err_evt: 8'h00, pkt_start: 1'b0, pkt_end: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign err_evt = r.err_evt;
  assign pkt_start = r.pkt_start;
  assign pkt_end = r.pkt_end;

endmodule // uei_rx_check

//--- logic/uei_tx_encode.sv
// Transmit path: bit stuffing, NRZI encoding and end-of-packet
`timescale 1ns/1ns
module uei_tx_encode (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_en,
  input wire logic start,
  input wire logic [7:0] data,
  input wire logic last,
  output logic tx_line,
  output logic tx_se0,
  output logic tx_oe,
  output logic busy,
  output logic done
);

  typedef struct packed {
    uei_pkg::uei_tx_state_t state;
    logic [7:0] shreg;
    logic [2:0] bitn;
    logic [2:0] ones;
    logic last;
    logic [1:0] eop_cnt;
    logic line;
    logic se0;
    logic oe;
    logic done;
  } uei_tx_t;

  uei_tx_t r;
  uei_tx_t next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.state)
      uei_pkg::UEI_TX_IDLE, uei_pkg::UEI_TX_HOLD: begin
        if (start) begin
          next_r.state = uei_pkg::UEI_TX_DATA;
          next_r.shreg = data;
          next_r.last = last;
          next_r.bitn = 3'h0;
          next_r.oe = 1'b1;
          if (r.state == uei_pkg::UEI_TX_IDLE) begin
            next_r.line = 1'b1;
            next_r.ones = 3'h0;
          end
        end
      end
      uei_pkg::UEI_TX_DATA: begin
        if (bit_en) begin
          if (r.ones == uei_pkg::STUFF_RUN) begin
            next_r.line = ~r.line; // RQ14
            next_r.ones = 3'h0;
            // Six ones closed the byte: the stuffed bit still goes out before EOP
            if (r.bitn == 3'h0) begin
              next_r.state = r.last ? uei_pkg::UEI_TX_EOP : uei_pkg::UEI_TX_HOLD;
              next_r.eop_cnt = 2'h0;
            end
          end else begin
            // A zero toggles J/K, a one holds the line
            next_r.line = r.shreg[0] ? r.line : ~r.line; // RQ13
            next_r.ones = r.shreg[0] ? r.ones + 3'h1 : 3'h0;
            next_r.shreg = {1'b0, r.shreg[7:1]};
            next_r.bitn = r.bitn + 3'h1;
            if (r.bitn == 3'h7 && next_r.ones != uei_pkg::STUFF_RUN) begin
              next_r.state = r.last ? uei_pkg::UEI_TX_EOP : uei_pkg::UEI_TX_HOLD;
              next_r.eop_cnt = 2'h0;
            end
          end
        end
      end
      uei_pkg::UEI_TX_EOP: begin
        if (bit_en) begin
          next_r.eop_cnt = r.eop_cnt + 2'h1;
          if (r.eop_cnt == 2'h2) begin
            next_r.se0 = 1'b0;
            next_r.line = 1'b1;
          end else if (r.eop_cnt == 2'h3) begin
            next_r.oe = 1'b0;
            next_r.done = 1'b1;
            next_r.state = uei_pkg::UEI_TX_IDLE;
          end else begin
            next_r.se0 = 1'b1;
          end
        end
      end
      default: begin
        next_r.state = uei_pkg::UEI_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{state: uei_pkg::UEI_TX_IDLE, shreg: 8'h00, bitn: 3'h0, ones: 3'h0,
             last: 1'b0, eop_cnt: 2'h0, line: 1'b1, se0: 1'b0, oe: 1'b0, done: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign tx_line = r.line;
  assign tx_se0 = r.se0;
  assign tx_oe = r.oe;
  assign done = r.done;
  assign busy = (r.state == uei_pkg::UEI_TX_DATA) || (r.state == uei_pkg::UEI_TX_EOP);

endmodule // uei_tx_encode

//--- logic/uei_top.sv
// USB serial engine error flags, enables, idle detect and APB register file
//
// What this block does
// RQ1: Enable bit 7 gates bit-stuffing violation onto the error interrupt.
// RQ2: Enable bit 4 gates bus turnaround time-out onto the error interrupt.
// RQ3: Enable bit 3 gates non-whole-byte data field onto the error interrupt.
// RQ4: Enable bit 2 gates 16-bit data CRC failure onto the error interrupt.
// RQ5: Enable bit 1 gates token 5-bit CRC rejection onto the error interrupt.
// RQ6: Enable bit 0 gates packet identifier check failure onto the error interrupt.
// RQ7: Enable bits 6 and 5 are unimplemented and read zero.
// RQ8: Top error interrupt is the OR of flags whose enable is set.
// RQ9: Flags set on their condition regardless of enables; software may poll them.
// RQ10: Idle flag sets after more than 3 ms without bus traffic.
// RQ11: Pull-up stays enabled throughout suspend.
// RQ12: Software enables module and pull-up only once VBUS attach is seen.
// RQ13: Transmit NRZI: zero toggles J/K, one holds the line.
// RQ14: Stuffing, unstuffing, NRZI and CRC handled in hardware; CRC is only checked on receive, the transmit path generates none.
// RQ15: Flags set at detection, even mid-token, cleared by writing zero.
// RQ16: Turnaround time-out after more than 16 idle bit times past EOP.
// RQ17: Writes to unimplemented enable bits are ignored.
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ns
module uei_top #(
  parameter int unsigned IDLE_LIMIT = uei_pkg::IDLE_CYCLES
) (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_LINE,
  input wire logic RX_SE0,
  input wire logic VBUS_ATTACH,
  output logic TX_LINE,
  output logic TX_SE0,
  output logic TX_OE,
  output logic PULLUP_EN,
  output logic USB_ENABLE,
  output logic TOP_ERROR_IRQ,
  output logic IRQ
);

  typedef struct packed {
    logic [7:0] err_flag;
    logic [7:0] err_en;
    logic [7:0] stat_flag;
    logic [7:0] stat_en;
    logic [1:0] ctrl;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] div;
    logic bit_en;
    logic turn_armed;
    logic [4:0] turn_cnt;
    logic [17:0] idle_cnt;
    logic idle_done;
    logic prev_rx;
    logic top_err;
    logic irq;
  } uei_top_state_t;

  uei_top_state_t r;
  uei_top_state_t next_r;

  logic [7:0] rx_err;
  logic rx_start;
  logic rx_end;
  logic tx_line;
  logic tx_se0;
  logic tx_oe;
  logic tx_busy;
  logic tx_done;

  uei_rx_check u_rx (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .bit_en(r.bit_en),
    .enable(r.ctrl[uei_pkg::CTRL_EN_BIT]),
    .rx_line(RX_LINE),
    .rx_se0(RX_SE0),
    .err_evt(rx_err),
    .pkt_start(rx_start),
    .pkt_end(rx_end)
  );

  uei_tx_encode u_tx (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .bit_en(r.bit_en),
    .start(r.tx_start),
    .data(r.tx_data),
    .last(r.tx_last),
    .tx_line(tx_line),
    .tx_se0(tx_se0),
    .tx_oe(tx_oe),
    .busy(tx_busy),
    .done(tx_done)
  );

  always_comb begin
    logic acc;
    logic wr;
    logic rd_hit;
    logic [7:0] err_evt;
    logic [7:0] stat_evt;
    logic turn_evt;
    logic idle_evt;
    logic activity;
    acc = 1'b0;
    wr = 1'b0;
    rd_hit = 1'b0;
    err_evt = 8'h00;
    stat_evt = 8'h00;
    turn_evt = 1'b0;
    idle_evt = 1'b0;
    activity = 1'b0;
    next_r = r;
    next_r.tx_start = 1'b0;

    // Bit-rate strobe; the serial paths advance only on it
    next_r.bit_en = (r.div == uei_pkg::BIT_DIV_LAST);
    next_r.div = next_r.bit_en ? 2'h0 : r.div + 2'h1;

    // Turnaround watch: armed by a received EOP, ended by any reply
    if (rx_end) begin
      next_r.turn_armed = 1'b1;
      next_r.turn_cnt = 5'h00;
    end else if (rx_start || r.tx_start || !r.ctrl[uei_pkg::CTRL_EN_BIT]) begin
      next_r.turn_armed = 1'b0;
    end else if (r.turn_armed && r.bit_en) begin
      if (r.turn_cnt == uei_pkg::TURNAROUND_BITS) begin
        turn_evt = 1'b1; // RQ16
        next_r.turn_armed = 1'b0;
      end else begin
        next_r.turn_cnt = r.turn_cnt + 5'h01;
      end
    end

    // Idle detect; one flag per quiet spell, rearmed by traffic
    next_r.prev_rx = RX_LINE;
    activity = (RX_LINE != r.prev_rx) || RX_SE0 || tx_oe;
    if (activity || !r.ctrl[uei_pkg::CTRL_EN_BIT]) begin
      next_r.idle_cnt = 18'h00000;
      next_r.idle_done = 1'b0;
    end else if (!r.idle_done) begin
      if (r.idle_cnt == 18'(IDLE_LIMIT)) begin
        idle_evt = 1'b1; // RQ10
        next_r.idle_done = 1'b1;
      end else begin
        next_r.idle_cnt = r.idle_cnt + 18'h00001;
      end
    end

    err_evt = rx_err;
    err_evt[uei_pkg::ERR_TURN_BIT] = turn_evt; // RQ2
    stat_evt[uei_pkg::STAT_IDLE_BIT] = idle_evt;
    stat_evt[uei_pkg::STAT_TXDONE_BIT] = tx_done;

    // APB: one wait state, then the write lands with pready high
    acc = PSEL && PENABLE;
    next_r.pready = acc && !r.pready;
    wr = acc && r.pready && PWRITE;
    rd_hit = 1'b1;
    next_r.prdata = 32'h00000000;
    case (PADDR)
      uei_pkg::ERR_FLAG_OFS: next_r.prdata[7:0] = r.err_flag;
      uei_pkg::ERR_EN_OFS: next_r.prdata[7:0] = r.err_en; // RQ7
      uei_pkg::STAT_FLAG_OFS: next_r.prdata[7:0] = r.stat_flag;
      uei_pkg::STAT_EN_OFS: next_r.prdata[7:0] = r.stat_en;
      uei_pkg::CTRL_OFS: begin
        next_r.prdata[1:0] = r.ctrl;
        next_r.prdata[uei_pkg::CTRL_ATTACH_BIT] = VBUS_ATTACH; // RQ12
      end
      uei_pkg::TX_OFS: begin
        next_r.prdata[7:0] = r.tx_data;
        next_r.prdata[uei_pkg::TX_LAST_BIT] = r.tx_last;
        next_r.prdata[uei_pkg::TX_BUSY_BIT] = tx_busy;
      end
      default: rd_hit = 1'b0;
    endcase
    next_r.pslverr = acc && !r.pready && !rd_hit;
    if (!next_r.pready) begin
      next_r.prdata = 32'h00000000;
    end

    // Error flags: write zero clears, a same-cycle event still wins
    next_r.err_flag = r.err_flag;
    if (wr && PADDR == uei_pkg::ERR_FLAG_OFS) begin
      next_r.err_flag = r.err_flag & PWDATA[7:0]; // RQ15
    end
    next_r.err_flag = (next_r.err_flag | err_evt) & uei_pkg::ERR_IMPL_MASK; // RQ9

    if (wr && PADDR == uei_pkg::ERR_EN_OFS) begin
      next_r.err_en = PWDATA[7:0] & uei_pkg::ERR_IMPL_MASK; // RQ17
    end

    if (wr && PADDR == uei_pkg::STAT_EN_OFS) begin
      next_r.stat_en = PWDATA[7:0] & uei_pkg::STAT_IMPL_MASK;
    end

    if (wr && PADDR == uei_pkg::CTRL_OFS) begin
      next_r.ctrl = PWDATA[1:0];
    end

    // A write while a byte is still going out is dropped
    if (wr && PADDR == uei_pkg::TX_OFS && !tx_busy) begin
      next_r.tx_data = PWDATA[7:0];
      next_r.tx_last = PWDATA[uei_pkg::TX_LAST_BIT];
      next_r.tx_start = r.ctrl[uei_pkg::CTRL_EN_BIT];
    end

    // Gated summary of the error flags
    next_r.top_err = |(next_r.err_flag & next_r.err_en); // RQ8 RQ1 RQ2 RQ3 RQ4 RQ5 RQ6

    // Status flags: write one clears the sticky bits, set still wins
    next_r.stat_flag = r.stat_flag;
    if (wr && PADDR == uei_pkg::STAT_FLAG_OFS) begin
      next_r.stat_flag = r.stat_flag & ~(PWDATA[7:0] & uei_pkg::STAT_STICKY_MASK);
    end
    next_r.stat_flag = (next_r.stat_flag | stat_evt) & uei_pkg::STAT_STICKY_MASK;
    next_r.stat_flag[uei_pkg::STAT_ERR_BIT] = next_r.top_err;

    next_r.irq = |(next_r.stat_flag & next_r.stat_en);
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      r <= '{err_flag: uei_pkg::ERR_FLAG_RESET, err_en: uei_pkg::ERR_EN_RESET,
             stat_flag: uei_pkg::STAT_RESET, stat_en: uei_pkg::STAT_RESET,
             ctrl: uei_pkg::CTRL_RESET, tx_data: 8'h00, tx_last: 1'b0, tx_start: 1'b0,
             prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0, div: 2'h0, bit_en: 1'b0,
             turn_armed: 1'b0, turn_cnt: 5'h00, idle_cnt: 18'h00000, idle_done: 1'b0,
             prev_rx: 1'b1, top_err: 1'b0, irq: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign TX_LINE = tx_line;
  assign TX_SE0 = tx_se0;
  assign TX_OE = tx_oe;
  // Pull-up follows software only; idle never drops it
  assign PULLUP_EN = r.ctrl[uei_pkg::CTRL_PULLUP_BIT]; // RQ11
  assign USB_ENABLE = r.ctrl[uei_pkg::CTRL_EN_BIT];
  assign TOP_ERROR_IRQ = r.top_err;
  assign IRQ = r.irq;

endmodule // uei_top

//--- testbench/uei_checker.sv
// Port-level assertions for the USB error interrupt block
`timescale 1ns/1ns
module uei_checker (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TX_SE0,
  input wire logic TX_OE,
  input wire logic PULLUP_EN,
  input wire logic USB_ENABLE,
  input wire logic TOP_ERROR_IRQ
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  logic mapped;
  logic err_wr;
  logic ctrl_wr;
  assign mapped = PADDR <= uei_pkg::TX_OFS && PADDR[1:0] == 2'h0;
  assign err_wr = PREADY && PWRITE && PADDR inside {uei_pkg::ERR_FLAG_OFS, uei_pkg::ERR_EN_OFS};
  assign ctrl_wr = PREADY && PWRITE && PADDR == uei_pkg::CTRL_OFS;
  a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready missing after wait state");
  a_ready_early: assert property (PSEL && !PENABLE |=> !PREADY)
    else $error("ready in first access cycle");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_slverr_map: assert property (PREADY |-> PSLVERR == !mapped)
    else $error("error response mismatch");
  a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside ready");
  a_en_unimpl: assert property (PREADY && !PWRITE && PADDR == uei_pkg::ERR_EN_OFS
    |-> (PRDATA & ~{24'h0, uei_pkg::ERR_IMPL_MASK}) == 32'h0) else $error("enable gap bits set");
  a_en_gate: assert property (err_wr && PADDR == uei_pkg::ERR_EN_OFS
    && (PWDATA[7:0] & uei_pkg::ERR_IMPL_MASK) == 8'h00 |=> !TOP_ERROR_IRQ)
    else $error("error irq with enables clear");
  a_flag_sticky: assert property ($fell(TOP_ERROR_IRQ) |-> $past(err_wr))
    else $error("error irq dropped without write");
  a_pullup_hold: assert property ($changed(PULLUP_EN) || $changed(USB_ENABLE)
    |-> $past(ctrl_wr)) else $error("pull-up or enable changed alone");
  a_se0_driven: assert property (TX_SE0 |-> TX_OE)
    else $error("SE0 while not driving");
endmodule // uei_checker

bind uei_top uei_checker chk_u (
  .CORE_CLK(CORE_CLK),
  .RESETN(RESETN),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PRDATA(PRDATA),
  .PREADY(PREADY),
  .PSLVERR(PSLVERR),
  .TX_SE0(TX_SE0),
  .TX_OE(TX_OE),
  .PULLUP_EN(PULLUP_EN),
  .USB_ENABLE(USB_ENABLE),
  .TOP_ERROR_IRQ(TOP_ERROR_IRQ)
);

//--- testbench/uei_usb_host.sv
// Host-side line model: sends NRZI packets, counts transmit line changes
`timescale 1ns/1ns
module uei_usb_host (
  input wire logic clk,
  output logic rx_line,
  output logic rx_se0,
  input wire logic tx_line,
  input wire logic tx_se0,
  input wire logic tx_oe,
  output int toggles
);
  logic prev_line = 1'b1;
  logic prev_se0 = 1'b0;
  initial begin
    rx_line = 1'b1;
    rx_se0 = 1'b0;
    toggles = 0;
  end
  // Changes out of SE0 are framing, not data
  always @(posedge clk) begin
    if (tx_oe && !tx_se0 && !prev_se0 && tx_line != prev_line)
      toggles <= toggles + 1;
    prev_line <= tx_line;
    prev_se0 <= tx_se0;
  end
  task automatic hold(input logic l, input logic s);
    rx_line <= l;
    rx_se0 <= s;
    repeat (4) @(posedge clk);
  endtask
  // Stuffing off only when the bench wants a violation
  task automatic send(input logic [47:0] b, input int n, input bit stuff);
    int run;
    run = 0;
    for (int i = 0; i < n; i++) begin
      hold(b[i] ? rx_line : !rx_line, 1'b0);
      run = b[i] ? run + 1 : 0;
      if (stuff && run == 6) begin
        hold(!rx_line, 1'b0);
        run = 0;
      end
    end
    hold(1'b0, 1'b1);
    hold(1'b0, 1'b1);
    hold(1'b1, 1'b0);
  endtask
endmodule // uei_usb_host

//--- testbench/tb.sv
// Self-checking bench for the USB error interrupt block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic vbus = 1'b0;
  logic [31:0] prdata, r;
  logic pready, pslverr, rx_line, rx_se0, tx_line, tx_se0, tx_oe, pullup_en, usb_en, err_irq, irq;
  logic e;
  int toggles;
  int miscompares = 0;
  int check_count = 0;
  int seed = 32'hf6cf;
  logic [7:0] pid_tab [5] = '{8'h00, 8'hE1, 8'hC3, 8'hC3, 8'hE1};
  int len_tab [5] = '{16, 32, 40, 36, 40};
  always #10 clk = ~clk;
  uei_top #(.IDLE_LIMIT(50)) dut_u (.CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_LINE(rx_line), .RX_SE0(rx_se0),
    .VBUS_ATTACH(vbus), .TX_LINE(tx_line), .TX_SE0(tx_se0), .TX_OE(tx_oe),
    .PULLUP_EN(pullup_en), .USB_ENABLE(usb_en), .TOP_ERROR_IRQ(err_irq), .IRQ(irq));
  uei_usb_host host_u (.clk(clk), .rx_line(rx_line), .rx_se0(rx_se0), .tx_line(tx_line),
    .tx_se0(tx_se0), .tx_oe(tx_oe), .toggles(toggles));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) miscompares++;
    @(posedge clk);
  endtask
  function automatic logic [7:0] exp_err(logic [47:0] b, int n);
    logic [4:0] c5;
    logic [15:0] c16;
    logic [7:0] x;
    c5 = 5'h1F;
    c16 = 16'hFFFF;
    x = 8'h10;
    x[0] = b[11:8] !== ~b[15:12];
    for (int i = 16; i < n; i++) begin
      c5 = {c5[3:0], 1'b0} ^ ((b[i] ^ c5[4]) ? 5'h05 : 5'h00);
      c16 = {c16[14:0], 1'b0} ^ ((b[i] ^ c16[15]) ? 16'h8005 : 16'h0000);
    end
    if (n > 16) begin
      x[3] = (n % 8) != 0;
      x[1] = b[9:8] == 2'h1 && c5 != 5'h0C;
      x[2] = b[9:8] == 2'h3 && c16 != 16'h800D;
    end
    return x;
  endfunction
  function automatic int exp_tog(logic [7:0] b);
    int t;
    int run;
    t = 0;
    run = 0;
    for (int i = 0; i < 8; i++) begin
      run = b[i] ? run + 1 : 0;
      t += b[i] ? 0 : 1;
      if (run == 6) begin
        t++;
        run = 0;
      end
    end
    return t;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  initial begin
    logic [47:0] pk;
    logic [7:0] ex, v, b;
    int t0, n;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    vbus <= 1'b1;
    @(posedge clk);
    apb(1'b0, uei_pkg::ERR_EN_OFS, 32'h0);
    `CHK("enable reset", 32'h0, r)
    apb(1'b0, uei_pkg::ERR_FLAG_OFS, 32'h0);
    `CHK("flags reset", 32'h0, r)
    apb(1'b1, uei_pkg::CTRL_OFS, 32'h3);
    apb(1'b0, uei_pkg::CTRL_OFS, 32'h0);
    `CHK("control", 32'h7, r)
    `CHK("module enable", 1'b1, usb_en)
    apb(1'b0, 8'h18, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    $display("test registers done");
    for (int p = 0; p < 5; p++) begin
      pk = 48'({$random(seed), $random(seed)});
      pk[15:0] = {pid_tab[p], 8'h80};
      if (p == 4) pk[31:16] = 16'hFFFF;
      ex = (p == 4) ? 8'h90 : exp_err(pk, len_tab[p]);
      host_u.send(pk, len_tab[p], p != 4);
      repeat (100) @(posedge clk);
      apb(1'b0, uei_pkg::ERR_FLAG_OFS, 32'h0);
      `CHK("error flags", {24'h0, ex}, r)
      for (int k = 0; k < 9; k++) begin
        v = (k < 8) ? 8'(1 << k) : 8'($random(seed));
        apb(1'b1, uei_pkg::ERR_EN_OFS, {24'h0, v});
        apb(1'b0, uei_pkg::ERR_EN_OFS, 32'h0);
        `CHK("enable", {24'h0, v & 8'h9F}, r)
        `CHK("irq gate", |(ex & v & 8'h9F), err_irq)
      end
      apb(1'b1, uei_pkg::ERR_EN_OFS, 32'h0);
      apb(1'b1, uei_pkg::ERR_FLAG_OFS, 32'h0);
      apb(1'b0, uei_pkg::ERR_FLAG_OFS, 32'h0);
      `CHK("flags cleared", 32'h0, r)
      $display("test packet %0d done", p);
    end
    for (int k = 0; k < 3; k++) begin
      b = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($random(seed));
      t0 = toggles;
      apb(1'b1, uei_pkg::TX_OFS, {23'h0, 1'b1, b});
      for (n = 0; n < 100 && tx_oe !== 1'b1; n++) @(posedge clk);
      for (n = 0; n < 400 && tx_oe !== 1'b0; n++) @(posedge clk);
      @(posedge clk);
      `CHK("tx toggles", exp_tog(b), toggles - t0)
    end
    $display("test transmit done");
    apb(1'b0, uei_pkg::STAT_FLAG_OFS, 32'h0);
    `CHK("tx done", 1'b1, r[3])
    apb(1'b1, uei_pkg::STAT_FLAG_OFS, 32'h18);
    apb(1'b0, uei_pkg::STAT_FLAG_OFS, 32'h0);
    `CHK("idle early", 1'b0, r[4])
    repeat (60) @(posedge clk);
    apb(1'b0, uei_pkg::STAT_FLAG_OFS, 32'h0);
    `CHK("idle set", 1'b1, r[4])
    `CHK("pullup kept", 1'b1, pullup_en)
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, uei_pkg::STAT_EN_OFS, 32'h10);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b1, uei_pkg::STAT_FLAG_OFS, 32'h10);
    `CHK("irq cleared", 1'b0, irq)
    $display("test idle done");
    close_out();
  end
endmodule // tb
